// File: rtl/move_ops_defs.svh
// Purpose: Constants for the code load and external move executor
// Assumes: 20 MHz core clock, one state per clock
// Notes: Included by the executor and state counter modules
// Overview of operation
// RULE_01 - Code load indexed by the instruction pointer first bumps the pointer, then loads A from code at A plus pointer, in two cycles.
// RULE_02 - Code load indexed by the data pointer loads A from code at A plus the 16-bit pointer, one byte, 12 states, two cycles.
// RULE_03 - External read with the 16-bit pointer places the addressed external byte in A.
// RULE_04 - External write with the 16-bit pointer stores A to the addressed external byte.
// RULE_05 - External read with 8-bit indirect address uses indirect register zero or one chosen by opcode bit 0.
// RULE_06 - The 8-bit indirect forms, read and write, drive the selected indirect register of the current bank on port 0.
// RULE_07 - The 16-bit form drives the pointer high byte on the upper address port.
// RULE_08 - The 16-bit form drives the pointer low byte on port 0.
// RULE_09 - Port 0 carries the low address first and then the data byte for every external move.
// RULE_10 - Every external move is one opcode byte and finishes in 12 states, two machine cycles.
// RULE_11 - For large memories in 8-bit form, software sets upper address bits by an output instruction beforehand.
// RULE_12 - The 8-bit form leaves the upper address port holding what software loaded, reaching the same large array.
// RULE_13 - None of these instructions changes the carry, auxiliary carry or overflow flags.
`ifndef MOVE_OPS_DEFS_SVH
`define MOVE_OPS_DEFS_SVH
`define OP_CODE_PC 8'h83
`define OP_CODE_DP 8'h93
`define OP_XRD_DP 8'he0
`define OP_XWR_DP 8'hf0
`define OP_XRD_RI 7'h71
`define OP_XWR_RI 7'h79
`define STATES_PER_CYCLE 4'h6
`define EXEC_STATES 4'hc
`define ADDR_PHASE_END 4'h5
`define PC_STEP 16'h0001
`define STATE_ONE 4'h1
`define STATE_ZERO 4'h0
`endif

// File: rtl/move_ops_exec.sv
// Purpose: Executes code loads and external data moves
// Assumes: One state per clock, opcode presented with start pulse
// Notes: Flags pass through untouched
`timescale 1ns/1ps
`default_nettype none
`include "move_ops_defs.svh"
module move_ops_exec
   import move_ops_pkg::*;
(
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic start_in,
   input wire logic [7:0] opcode_in,
   input wire logic [7:0] acc_in,
   input wire logic [15:0] instruction_pointer_in,
   input wire logic [15:0] data_pointer_16_in,
   input wire logic [7:0] indirect_reg_zero_in,
   input wire logic [7:0] indirect_reg_one_in,
   input wire logic [7:0] upper_address_latch_in,
   input wire logic [2:0] flags_in,
   input wire logic [7:0] code_data_in,
   input wire logic [7:0] port0_in,
   output logic busy_out,
   output logic done_out,
   output logic acc_we_out,
   output logic [7:0] acc_out,
   output logic [15:0] instruction_pointer_out,
   output logic ip_we_out,
   output logic [2:0] flags_out,
   output logic [15:0] code_addr_out,
   output logic code_rd_out,
   output logic [7:0] port0_out,
   output logic port0_oe_out,
   output logic [7:0] upper_address_port_out,
   output logic ext_rd_out,
   output logic ext_wr_out,
   output logic illegal_out
);
   import move_ops_pkg::*;
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function automatic op_kind_e decode(input logic [7:0] op);
      op_kind_e k;
      k = K_NONE;
      if (op == `OP_CODE_PC) k = K_CODE_PC;
      else if (op == `OP_CODE_DP) k = K_CODE_DP;
      else if (op == `OP_XRD_DP || op[7:1] == `OP_XRD_RI) k = K_XRD;
      else if (op == `OP_XWR_DP || op[7:1] == `OP_XWR_RI) k = K_XWR;
      return k;
   endfunction
   // ----------------------------------------
   // State
   // ----------------------------------------
   exec_state_e st_reg, st_next;
   op_kind_e kind_reg, kind_next;
   logic wide_reg, wide_next;
   logic [15:0] addr_reg, addr_next;
   logic [7:0] acc_reg, acc_next;
   logic [15:0] ip_reg, ip_next;
   logic ip_we_reg, ip_we_next;
   logic acc_we_reg, acc_we_next;
   logic done_reg, done_next;
   logic [7:0] p0_reg, p0_next;
   logic p0_oe_reg, p0_oe_next;
   logic [7:0] p2_reg, p2_next;
   logic rd_reg, rd_next, wr_reg, wr_next, crd_reg, crd_next;
   logic [15:0] caddr_reg, caddr_next;
   logic ill_reg, ill_next;
   logic [2:0] flags_reg;
   logic [3:0] cnt;
   logic last;
   logic [7:0] ri_val;
   logic busy_reg, busy_next;
   state_counter u_cnt (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .run_in(st_reg == ST_EXEC),
      .count_out(cnt),
      .last_out(last)
   );
   assign ri_val = opcode_in[0] ? indirect_reg_one_in : indirect_reg_zero_in; // RULE_05
   always_comb begin
      st_next = st_reg;
      kind_next = kind_reg;
      wide_next = wide_reg;
      addr_next = addr_reg;
      acc_next = acc_reg;
      ip_next = ip_reg;
      ip_we_next = 1'b0;
      acc_we_next = 1'b0;
      done_next = 1'b0;
      p0_next = p0_reg;
      p0_oe_next = 1'b0;
      p2_next = p2_reg;
      rd_next = 1'b0;
      wr_next = 1'b0;
      crd_next = 1'b0;
      caddr_next = caddr_reg;
      ill_next = 1'b0;
      unique case (st_reg)
         ST_IDLE: begin
            if (start_in) begin
               kind_next = decode(opcode_in);
               acc_next = acc_in;
               wide_next = opcode_in[1] == 1'b0;
               if (decode(opcode_in) == K_NONE) begin
                  ill_next = 1'b1;
               end else begin
                  st_next = ST_EXEC;
               end
               if (opcode_in == `OP_CODE_PC) begin
                  ip_next = instruction_pointer_in + `PC_STEP; // RULE_01
                  ip_we_next = 1'b1; // RULE_01
                  addr_next = instruction_pointer_in + `PC_STEP + {8'h00, acc_in}; // RULE_01
               end else if (opcode_in == `OP_CODE_DP) begin
                  addr_next = data_pointer_16_in + {8'h00, acc_in}; // RULE_02
               end else if (opcode_in[1] == 1'b0) begin
                  addr_next = data_pointer_16_in; // RULE_03 RULE_04
               end else begin
                  addr_next = {upper_address_latch_in, ri_val}; // RULE_06 RULE_12
               end
            end
         end
         ST_EXEC: begin
            if (kind_reg == K_CODE_PC || kind_reg == K_CODE_DP) begin
               caddr_next = addr_reg;
               crd_next = 1'b1;
               if (last) begin
                  acc_next = code_data_in; // RULE_01 RULE_02
                  acc_we_next = 1'b1;
               end
            end else begin
               // Address phase then data phase on port 0
               if (cnt < `ADDR_PHASE_END) begin
                  p0_next = addr_reg[7:0]; // RULE_08 RULE_06 RULE_09
                  p0_oe_next = 1'b1;
                  if (wide_reg) p2_next = addr_reg[15:8]; // RULE_07
                  else p2_next = upper_address_latch_in; // RULE_12
               end else if (kind_reg == K_XWR) begin
                  p0_next = acc_reg; // RULE_04 RULE_09
                  p0_oe_next = 1'b1;
                  wr_next = 1'b1;
               end else begin
                  rd_next = 1'b1;
                  if (last) begin
                     acc_next = port0_in; // RULE_03 RULE_05 RULE_09
                     acc_we_next = 1'b1;
                  end
               end
            end
            if (last) begin
               st_next = ST_DONE; // RULE_10
               done_next = 1'b1;
            end
         end
         ST_DONE: begin
            st_next = ST_IDLE;
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
      busy_next = (st_next != ST_IDLE);
   end
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_reg <= ST_IDLE;
         kind_reg <= K_NONE;
         wide_reg <= 1'b0;
         addr_reg <= 16'h0000;
         acc_reg <= 8'h00;
         ip_reg <= 16'h0000;
         ip_we_reg <= 1'b0;
         acc_we_reg <= 1'b0;
         done_reg <= 1'b0;
         p0_reg <= 8'hff;
         p0_oe_reg <= 1'b0;
         p2_reg <= 8'hff;
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         crd_reg <= 1'b0;
         caddr_reg <= 16'h0000;
         ill_reg <= 1'b0;
         flags_reg <= 3'h0;
         busy_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         kind_reg <= kind_next;
         wide_reg <= wide_next;
         addr_reg <= addr_next;
         acc_reg <= acc_next;
         ip_reg <= ip_next;
         ip_we_reg <= ip_we_next;
         acc_we_reg <= acc_we_next;
         done_reg <= done_next;
         p0_reg <= p0_next;
         p0_oe_reg <= p0_oe_next;
         p2_reg <= p2_next;
         rd_reg <= rd_next;
         wr_reg <= wr_next;
         crd_reg <= crd_next;
         caddr_reg <= caddr_next;
         ill_reg <= ill_next;
         flags_reg <= flags_in; // RULE_13
         busy_reg <= busy_next;
      end
   end
   assign busy_out = busy_reg;
   assign done_out = done_reg;
   assign acc_we_out = acc_we_reg;
   assign acc_out = acc_reg;
   assign instruction_pointer_out = ip_reg;
   assign ip_we_out = ip_we_reg;
   assign flags_out = flags_reg;
   assign code_addr_out = caddr_reg;
   assign code_rd_out = crd_reg;
   assign port0_out = p0_reg;
   assign port0_oe_out = p0_oe_reg;
   assign upper_address_port_out = p2_reg;
   assign ext_rd_out = rd_reg;
   assign ext_wr_out = wr_reg;
   assign illegal_out = ill_reg;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_start_ext;
      st_reg == ST_IDLE && start_in && decode(opcode_in) inside {K_XRD, K_XWR};
   endsequence
   sequence s_start_rd;
      st_reg == ST_IDLE && start_in && decode(opcode_in) == K_XRD;
   endsequence
   sequence s_start_wr;
      st_reg == ST_IDLE && start_in && decode(opcode_in) == K_XWR;
   endsequence
   sequence s_start_code;
      st_reg == ST_IDLE && start_in && decode(opcode_in) inside {K_CODE_PC, K_CODE_DP};
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_done_twelve: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_10
      st_reg == ST_IDLE && start_in && decode(opcode_in) != K_NONE |-> ##13 done_reg)
      else $error("instruction did not finish in 12 states");
   a_busy_hold: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_10
      st_reg == ST_EXEC && !last |=> st_reg == ST_EXEC)
      else $error("instruction cut short");
   a_ip_bump: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_01
      st_reg == ST_IDLE && start_in && opcode_in == `OP_CODE_PC |=>
      ip_we_reg && ip_reg == $past(instruction_pointer_in) + `PC_STEP)
      else $error("pointer not advanced");
   a_ip_once: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_01
      ip_we_reg |=> !ip_we_reg)
      else $error("pointer advanced twice");
   a_code_dp_addr: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_02
      st_reg == ST_IDLE && start_in && opcode_in == `OP_CODE_DP |=>
      addr_reg == $past(data_pointer_16_in) + {8'h00, $past(acc_in)})
      else $error("code address wrong");
   a_code_fetch: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_02
      s_start_code |-> ##2 (crd_reg && caddr_reg == $past(addr_reg))
      ##11 (acc_we_reg && acc_reg == $past(code_data_in)))
      else $error("code byte not loaded");
   a_read_data: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_03
      s_start_rd |-> ##12 rd_reg ##1 (acc_we_reg && acc_reg == $past(port0_in)))
      else $error("read byte not loaded");
   a_write_data: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_04
      s_start_wr |-> ##7 (wr_reg && p0_oe_reg && p0_reg == $past(acc_in, 7)))
      else $error("write byte wrong");
   a_write_no_load: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_04
      s_start_wr |-> ##13 (done_reg && !acc_we_reg))
      else $error("write loaded the accumulator");
   a_wide_high: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_07
      st_reg == ST_IDLE && start_in && (opcode_in == `OP_XRD_DP || opcode_in == `OP_XWR_DP)
      |-> ##2 p2_reg == $past(data_pointer_16_in[15:8], 2))
      else $error("upper address wrong");
   a_wide_low: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_08
      st_reg == ST_IDLE && start_in && opcode_in == `OP_XRD_DP
      |-> ##2 p0_oe_reg && p0_reg == $past(data_pointer_16_in[7:0], 2))
      else $error("low address wrong");
   a_wide_low_wr: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_08
      st_reg == ST_IDLE && start_in && opcode_in == `OP_XWR_DP
      |-> ##2 p0_oe_reg && p0_reg == $past(data_pointer_16_in[7:0], 2))
      else $error("low address wrong on write");
   a_ri_addr: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_05
      st_reg == ST_IDLE && start_in && opcode_in[7:1] == `OP_XRD_RI
      |-> ##2 p0_reg == $past(ri_val, 2))
      else $error("indirect address wrong");
   a_ri_write: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_06
      st_reg == ST_IDLE && start_in && opcode_in[7:1] == `OP_XWR_RI
      |-> ##2 p0_reg == $past(ri_val, 2) ##5 wr_reg && p0_reg == acc_reg)
      else $error("indirect write wrong");
   a_mux_phase: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_09
      s_start_ext |-> ##2 (!wr_reg && !rd_reg) [*5] ##1 (wr_reg || rd_reg))
      else $error("port 0 phases wrong");
   a_read_release: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_09
      s_start_rd |-> ##7 (rd_reg && !p0_oe_reg))
      else $error("port 0 still driven in read data phase");
   a_mixed_upper: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_12
      st_reg == ST_IDLE && start_in && opcode_in[7:1] == `OP_XRD_RI
      |-> ##2 p2_reg == $past(upper_address_latch_in))
      else $error("upper port not held for indirect move");
   a_flags_keep: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE_13
      1'b1 |=> flags_reg == $past(flags_in))
      else $error("flags changed");
endmodule // move_ops_exec
`default_nettype wire

// File: rtl/move_ops_pkg.sv
// Purpose: Types for the move executor
// Assumes: Defs header present
// Notes: Types only
package move_ops_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_DONE = 3'b100
   } exec_state_e;
   typedef enum logic [2:0] {
      K_CODE_PC,
      K_CODE_DP,
      K_XRD,
      K_XWR,
      K_NONE
   } op_kind_e;
endpackage

// File: rtl/state_counter.sv
// Purpose: Counts states within a two machine cycle instruction
// Assumes: Single clock
// Notes: Wraps to zero on done
`timescale 1ns/1ps
`default_nettype none
`include "move_ops_defs.svh"
module state_counter (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic run_in,
   output logic [3:0] count_out,
   output logic last_out
);
   logic [3:0] count_reg;
   logic [3:0] count_next;
   always_comb begin
      count_next = `STATE_ZERO;
      if (run_in && count_reg != (`EXEC_STATES - `STATE_ONE)) begin
         count_next = count_reg + `STATE_ONE;
      end
   end
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         count_reg <= `STATE_ZERO;
      end else begin
         count_reg <= count_next;
      end
   end
   assign count_out = count_reg;
   assign last_out = run_in && (count_reg == (`EXEC_STATES - `STATE_ONE));
endmodule // state_counter
`default_nettype wire

// File: sim/code_and_external_move_ops_bench.sv
// Purpose: Self-checking bench for the move executor
// Assumes: Partner RAM model, code memory as a fixed formula
// Notes: Small address pool so both address forms overlap
`timescale 1ns/1ps
`default_nettype none
module code_and_external_move_ops_bench;
   logic clk_in, rstn_in, start_in, busy_out, done_out, acc_we_out, ip_we_out, code_rd_out;
   logic port0_oe_out, ext_rd_out, ext_wr_out, illegal_out;
   logic [7:0] opcode_in, acc_in, indirect_reg_zero_in, indirect_reg_one_in, upper_address_latch_in;
   logic [7:0] code_data_in, port0_in, acc_out, port0_out, upper_address_port_out;
   logic [15:0] instruction_pointer_in, data_pointer_16_in, instruction_pointer_out, code_addr_out;
   logic [2:0] flags_in, flags_out;
   logic [7:0] mem_q [int];
   logic [7:0] ops [0:8] = '{8'h83, 8'h93, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3, 8'ha5};
   int errors = 0, checks_done = 0, seed = 16;
   // ----------------------------------------
   // Design and partner
   // ----------------------------------------
   move_ops_exec dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .start_in(start_in),
      .opcode_in(opcode_in), .acc_in(acc_in), .instruction_pointer_in(instruction_pointer_in),
      .data_pointer_16_in(data_pointer_16_in), .indirect_reg_zero_in(indirect_reg_zero_in),
      .indirect_reg_one_in(indirect_reg_one_in), .upper_address_latch_in(upper_address_latch_in),
      .flags_in(flags_in), .code_data_in(code_data_in), .port0_in(port0_in),
      .busy_out(busy_out), .done_out(done_out), .acc_we_out(acc_we_out), .acc_out(acc_out),
      .instruction_pointer_out(instruction_pointer_out), .ip_we_out(ip_we_out),
      .flags_out(flags_out), .code_addr_out(code_addr_out), .code_rd_out(code_rd_out),
      .port0_out(port0_out), .port0_oe_out(port0_oe_out),
      .upper_address_port_out(upper_address_port_out), .ext_rd_out(ext_rd_out),
      .ext_wr_out(ext_wr_out), .illegal_out(illegal_out));
   ext_data_ram_model ram_u (.clk_in(clk_in), .port0_out(port0_out),
      .port0_oe_out(port0_oe_out), .upper_address_port_out(upper_address_port_out),
      .ext_rd_out(ext_rd_out), .ext_wr_out(ext_wr_out), .port0_in(port0_in));
   assign code_data_in = code_addr_out[7:0] ^ code_addr_out[15:8] ^ 8'ha5;
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // ----------------------------------------
   // Checks and verdict
   // ----------------------------------------
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // One instruction with reference model
   // ----------------------------------------
   task automatic run_op(input logic [7:0] op);
      logic [15:0] ea;
      logic [7:0] ri, exp_acc;
      logic seen;
      int n;
      @(posedge clk_in);
      opcode_in <= op;
      acc_in <= 8'($random(seed));
      instruction_pointer_in <= 16'($random(seed));
      data_pointer_16_in <= 16'($random(seed)) & 16'h0303;
      indirect_reg_zero_in <= 8'($random(seed)) & 8'h03;
      indirect_reg_one_in <= 8'($random(seed)) & 8'h03;
      upper_address_latch_in <= 8'($random(seed)) & 8'h03;
      flags_in <= 3'($random(seed));
      start_in <= 1'b1;
      @(posedge clk_in);
      start_in <= 1'b0;
      #1;
      ri = op[0] ? indirect_reg_one_in : indirect_reg_zero_in;
      case (op)
         8'h83: ea = {8'h00, acc_in} + instruction_pointer_in + 16'h0001;
         8'h93: ea = {8'h00, acc_in} + data_pointer_16_in;
         8'he0, 8'hf0: ea = data_pointer_16_in;
         default: ea = {upper_address_latch_in, ri};
      endcase
      chk("ip_we", {15'h0000, op == 8'h83}, {15'h0000, ip_we_out});
      if (op == 8'ha5) begin
         seen = illegal_out;
         @(posedge clk_in);
         #1;
         chk("illegal", 16'h0001, {15'h0000, seen | illegal_out});
         chk("busy", 16'h0000, {15'h0000, busy_out});
         return;
      end
      for (n = 1; n <= 20; n++) begin
         @(posedge clk_in);
         start_in <= (n == 5);
         #1;
         if (n == 4 && op[7:5] == 3'h7) begin
            chk("port0_oe", 16'h0001, {15'h0000, port0_oe_out});
            chk("port0_addr", {8'h00, ea[7:0]}, {8'h00, port0_out});
            chk("upper_port", {8'h00, ea[15:8]}, {8'h00, upper_address_port_out});
         end
         if (n == 4 && op[7:5] != 3'h7) begin
            chk("code_rd", 16'h0001, {15'h0000, code_rd_out});
            chk("code_addr", ea, code_addr_out);
         end
         if (n == 8 && op[7:5] == 3'h7) begin
            chk("strobes", {14'h0, op[4], ~op[4]}, {14'h0, ext_wr_out, ext_rd_out});
         end
         if (done_out === 1'b1) begin
            break;
         end
      end
      chk("done_cycle", 16'd12, 16'(n));
      if (n > 20) begin
         final_report();
      end
      chk("flags", {13'h0000, flags_in}, {13'h0000, flags_out});
      exp_acc = mem_q.exists(ea) ? mem_q[ea] : (8'(ea * 3) ^ ea[15:8]);
      if (op[7:4] == 4'hf) begin
         mem_q[ea] = acc_in;
         chk("acc_we_wr", 16'h0000, {15'h0000, acc_we_out});
      end else begin
         if (op[7:4] != 4'he) begin
            exp_acc = ea[7:0] ^ ea[15:8] ^ 8'ha5;
         end
         chk("acc_we", 16'h0001, {15'h0000, acc_we_out});
         chk("acc", {8'h00, exp_acc}, {8'h00, acc_out});
      end
      if (op == 8'h83) begin
         chk("ip", instruction_pointer_in + 16'h0001, instruction_pointer_out);
      end
   endtask
   initial begin
      {rstn_in, start_in, opcode_in, acc_in, flags_in} = '0;
      {instruction_pointer_in, data_pointer_16_in, upper_address_latch_in} = '0;
      {indirect_reg_zero_in, indirect_reg_one_in} = '0;
      repeat (8) @(posedge clk_in);
      rstn_in <= 1'b1;
      for (int i = 0; i < 120; i++) begin
         run_op(ops[$unsigned($random(seed)) % 9]);
      end
      final_report();
   end
endmodule // code_and_external_move_ops_bench
`default_nettype wire

// File: sim/ext_data_ram_model.sv
// Purpose: External data RAM on the multiplexed port 0 lines
// Assumes: Address phase with oe high and no strobe, then rd or wr
// Notes: Released bus shows inverse of last byte
`timescale 1ns/1ps
`default_nettype none
module ext_data_ram_model (
   input wire logic clk_in,
   input wire logic [7:0] port0_out,
   input wire logic port0_oe_out,
   input wire logic [7:0] upper_address_port_out,
   input wire logic ext_rd_out,
   input wire logic ext_wr_out,
   output logic [7:0] port0_in
);
   logic [7:0] mem [0:65535];
   logic [15:0] addr_reg;
   logic [7:0] last_reg;
   initial begin
      for (int a = 0; a < 65536; a++) begin
         mem[a] = 8'(a * 3) ^ 8'(a >> 8);
      end
      addr_reg = 16'h0000;
      last_reg = 8'h00;
   end
   always @(posedge clk_in) begin
      if (port0_oe_out && !ext_rd_out && !ext_wr_out) begin
         addr_reg <= {upper_address_port_out, port0_out};
      end
      if (ext_wr_out) begin
         mem[addr_reg] <= port0_out;
      end
      last_reg <= port0_in;
   end
   assign port0_in = ext_rd_out ? mem[addr_reg] : ~last_reg;
endmodule // ext_data_ram_model
`default_nettype wire
